// file: logic/fnv_regs.svh
// Constants for the flash map and configuration page loader
`ifndef FNV_REGS_SVH
`define FNV_REGS_SVH
`define FNV_CODE_PAGES      6'h20
`define FNV_PAGE_BYTES      16'h0200
`define FNV_CFG_BYTES       16'h0200
`define FNV_EXT0_MCU        16'hfa00
`define FNV_EXT1_MCU        16'hfb00
`define FNV_NRM0_MCU        16'hfc00
`define FNV_NRM1_MCU        16'hfe00
`define FNV_NRM0_SPI        16'h4400
`define FNV_NRM1_SPI        16'h4600
`define FNV_EXT0_PAGE       6'h20
`define FNV_EXT1_PAGE       6'h21
`define FNV_NRM0_PAGE       6'h22
`define FNV_NRM1_PAGE       6'h23
`define FNV_OFS_UNPROT      9'h020
`define FNV_OFS_RDIS        9'h023
`define FNV_OFS_DEBUG       9'h024
`define FNV_ERASED          8'hff
`define FNV_TOP_FIRST       16'hfff0
`define FNV_TOP_COUNT       5'h10
`endif

// file: logic/fnv_pkg.sv
// Types for the flash map and configuration page loader
`default_nettype none
package fnv_pkg;
  typedef enum logic [2:0] {
    ST_CFG_COUNT, ST_CFG_RDIS, ST_CFG_DEBUG, ST_TOP_SCAN, ST_TOP_LAST, ST_READY
  } fnv_boot_t;
endpackage : fnv_pkg
`default_nettype wire

// file: logic/fnv_flash_map.sv
// Flash map decode, boot load of configuration, and access gating
`include "fnv_regs.svh"
`default_nettype none
module fnv_flash_map (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Flash array read port used during boot
  output logic             bootRead,
  output logic             bootCfgSel,
  output logic [15:0]      bootAddr,
  input  wire logic [7:0]  bootData,
  // MCU access request
  input  wire logic        mcuReq,
  input  wire logic        mcuWrite,
  input  wire logic        mcuErase,
  input  wire logic        mcuDataSpace,
  input  wire logic [15:0] mcuAddr,
  input  wire logic [5:0]  mcuErasePage,
  output logic             mcuGrant,
  output logic             mcuInData,
  output logic [5:0]       mcuPage,
  // SPI access request
  input  wire logic        spiReq,
  input  wire logic        spiRead,
  input  wire logic        spiErase,
  input  wire logic        spiCfgSel,
  input  wire logic [15:0] spiAddr,
  input  wire logic [5:0]  spiErasePage,
  input  wire logic        spiDisableCmd,
  input  wire logic        spiEraseAllCmd,
  output logic             spiGrant,
  output logic [5:0]       spiPage,
  // Configuration state
  output logic             ready,
  output logic [7:0]       unprotectedPageCount,
  output logic             readbackDisabled,
  output logic             hwDebugEnable,
  output logic             protectedStartSelect,
  output logic [15:0]      startAddr
);

  fnv_pkg::fnv_boot_t state;          // Boot sequencer state
  logic [3:0]         scanIdx;        // Index into top 16 data bytes
  logic               parity;         // Running parity of top bytes
  logic [7:0]         rdisByte;       // Loaded readback-disable byte
  logic               disableUsed;    // One-shot of the disable command

  // Boot timeline after reset release, one read per clock:
  //   cycle 0      configuration offset 0x020, unprotected page count
  //   cycle 1      count captured, offset 0x023 readback-disable byte
  //   cycle 2      disable byte captured, offset 0x024 debug byte
  //   cycle 3..18  top sixteen data bytes, 0xfff0 up to 0xffff
  //   cycle 19     last data byte arrives, array port idle
  //   cycle 20     ready set, start address and start select settle
  // The array answers one clock after the address, so every capture
  // runs one state behind the read that fed it.
  // Requests seen before ready are refused on both ports; this keeps
  // the protection split and readback gate from acting on reset values.
  // Trade-off: a plain counter sequencer costs twenty cycles per reset,
  // which is far below any boot budget and needs no buffer.
  // Limitation: configuration is only read at reset; a later change to
  // the stored page has no effect until the next reset.
  // The debug byte capture shares the first scan cycle, because that is
  // where its data arrives; the parity skips that cycle for the same reason.
  // Hazard: any extra wait state in the array would shift every capture,
  // so the array must answer in exactly one cycle.

  // Page number of a code address; code pages are 512 bytes
  function automatic logic [5:0] codePage(input logic [15:0] a);
    codePage = {1'b0, a[13:9]};
  endfunction : codePage

  // True when the code page lies in the MCU-protected area
  function automatic logic isProtected(input logic [5:0] p, input logic [7:0] n);
    isProtected = (n < 8'(`FNV_CODE_PAGES)) && ({2'b00, p} >= n);
  endfunction : isProtected

  // Boot sequencer: read config bytes, then parity over top of data memory
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= fnv_pkg::ST_CFG_COUNT;
      scanIdx <= 4'h0;
    end else begin
      unique case (state)
        fnv_pkg::ST_CFG_COUNT: state <= fnv_pkg::ST_CFG_RDIS;
        fnv_pkg::ST_CFG_RDIS:  state <= fnv_pkg::ST_CFG_DEBUG;
        fnv_pkg::ST_CFG_DEBUG: state <= fnv_pkg::ST_TOP_SCAN;
        fnv_pkg::ST_TOP_SCAN: begin
          scanIdx <= scanIdx + 4'h1;
          if (scanIdx == 4'hf) begin
            state <= fnv_pkg::ST_TOP_LAST;
          end
        end
        fnv_pkg::ST_TOP_LAST: state <= fnv_pkg::ST_READY;
        fnv_pkg::ST_READY:    state <= fnv_pkg::ST_READY;
        default:              state <= fnv_pkg::ST_CFG_COUNT;
      endcase
    end
  end

  // Boot read address; array data returns one cycle after the address
  always_comb begin
    bootRead = (state != fnv_pkg::ST_READY) && (state != fnv_pkg::ST_TOP_LAST);
    bootCfgSel = 1'b0;
    bootAddr = 16'h0000;
    unique case (state)
      fnv_pkg::ST_CFG_COUNT: begin
        bootCfgSel = 1'b1;
        bootAddr = {7'h00, `FNV_OFS_UNPROT};
      end
      fnv_pkg::ST_CFG_RDIS: begin
        bootCfgSel = 1'b1;
        bootAddr = {7'h00, `FNV_OFS_RDIS};
      end
      fnv_pkg::ST_CFG_DEBUG: begin
        bootCfgSel = 1'b1;
        bootAddr = {7'h00, `FNV_OFS_DEBUG};
      end
      fnv_pkg::ST_TOP_SCAN: bootAddr = `FNV_TOP_FIRST + {12'h000, scanIdx};
      default: bootAddr = 16'h0000;
    endcase
  end

  // Capture of configuration bytes one cycle after each read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      unprotectedPageCount <= `FNV_ERASED;
      rdisByte <= `FNV_ERASED;
      hwDebugEnable <= 1'b0;
    end else begin
      if (state == fnv_pkg::ST_CFG_RDIS) begin
        unprotectedPageCount <= bootData;
      end
      if (state == fnv_pkg::ST_CFG_DEBUG) begin
        rdisByte <= bootData;
      end
      if (state == fnv_pkg::ST_TOP_SCAN && scanIdx == 4'h0) begin
        hwDebugEnable <= (bootData != `FNV_ERASED);
      end
    end
  end

  // Parity over top 16 data bytes; first scan cycle carries the debug byte
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      parity <= 1'b0;
      protectedStartSelect <= 1'b0;
    end else begin
      if (state == fnv_pkg::ST_TOP_SCAN && scanIdx != 4'h0) begin
        parity <= parity ^ (^bootData);
      end
      if (state == fnv_pkg::ST_TOP_LAST) begin
        protectedStartSelect <= parity ^ (^bootData);
      end
    end
  end

  // Readback gate notes:
  //   Two sources can close external main-block access: the stored byte
  //   loaded at boot, and the dedicated disable command seen since then.
  //   The command is accepted only once boot is complete, so a command
  //   racing the boot read is ignored and leaves the gate as loaded.
  //   Erase-all clears the command latch and takes priority when both
  //   arrive together; the stored byte itself is erased by the array, so
  //   its effect ends at the next reset.
  //   Limitation: between erase-all and the next reset a stored non-erased
  //   byte still holds the gate closed; hosts should reset after erase-all.
  //   Configuration page reads stay open so a host can inspect the setup.
  //   Trade-off: the gate is a combinational OR of two flops, so it follows
  //   the command one cycle after its edge with no extra register.
  // Readback-disable one-shot; erase-all wins and restores erased state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      disableUsed <= 1'b0;
    end else if (spiEraseAllCmd) begin
      disableUsed <= 1'b0;
    end else if (spiDisableCmd && state == fnv_pkg::ST_READY) begin
      disableUsed <= 1'b1;
    end
  end

  // Disable holds if loaded non-erased or set by command since boot
  always_comb begin
    readbackDisabled = (rdisByte != `FNV_ERASED) || disableUsed;
  end

  // Ready flag and start address; protected start only if split active
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ready <= 1'b0;
      startAddr <= 16'h0000;
    end else if (state == fnv_pkg::ST_TOP_LAST) begin
      ready <= 1'b1;
      if ((parity ^ (^bootData)) && unprotectedPageCount < 8'(`FNV_CODE_PAGES)) begin
        startAddr <= {unprotectedPageCount[6:0], 9'h000};
      end else begin
        startAddr <= 16'h0000;
      end
    end
  end

  // MCU port notes:
  //   Data space addresses from 0xfa00 upward select the four data pages;
  //   the two extended pages are 256 bytes, the two normal ones 512 bytes.
  //   Code addresses use bits 13 to 9 as the page number, 32 pages in all.
  //   Erase requests carry the page number directly; only data pages and
  //   unprotected code pages are accepted from the processor.
  //   Writes and erases into the protected upper code area are refused
  //   quietly; reads there are always granted, since protection only
  //   guards against processor modification.
  //   Hazard: software must select data space for data page access, or the
  //   address is decoded as a code page and checked against the split.
  //   Page numbers above 35 are never granted for an erase.
  //   All outputs of this decode are combinational and follow the inputs
  //   in the same cycle; the requester samples them before the next edge.
  // MCU decode: data pages in data space, code pages elsewhere
  always_comb begin
    mcuInData = 1'b0;
    mcuPage = codePage(mcuAddr);
    mcuGrant = 1'b0;
    if (mcuErase) begin
      mcuPage = mcuErasePage;
      mcuInData = (mcuErasePage >= `FNV_EXT0_PAGE) && (mcuErasePage <= `FNV_NRM1_PAGE);
    end else if (mcuDataSpace && mcuAddr >= `FNV_EXT0_MCU) begin
      mcuInData = 1'b1;
      if (mcuAddr < `FNV_EXT1_MCU) mcuPage = `FNV_EXT0_PAGE;
      else if (mcuAddr < `FNV_NRM0_MCU) mcuPage = `FNV_EXT1_PAGE;
      else if (mcuAddr < `FNV_NRM1_MCU) mcuPage = `FNV_NRM0_PAGE;
      else mcuPage = `FNV_NRM1_PAGE;
    end
    if (mcuReq && ready) begin
      if ((mcuWrite || mcuErase) && !mcuInData) begin
        mcuGrant = !isProtected(mcuPage, unprotectedPageCount) && mcuPage < `FNV_CODE_PAGES;
      end else begin
        mcuGrant = mcuErase ? mcuInData : 1'b1;
      end
    end
  end

  // SPI port notes:
  //   The host sees the code area at 0x0000 to 0x3fff and the two normal
  //   data pages at 0x4400 and 0x4600; the extended pages have no host
  //   address and their erase numbers are refused.
  //   Protection of the code split does not apply to the host, which may
  //   read, erase and write protected pages while the gate is open.
  //   Configuration selects target the separate page; reads there are
  //   always granted once boot has finished.
  //   Limitation: code addresses between 0x4000 and 0x43ff alias onto code
  //   pages by their low bits; hosts must stay inside the documented map.
  //   Grant is combinational and holds only while the request holds.
  // SPI decode: normal data pages visible, extended pages never
  always_comb begin
    spiPage = spiErase ? spiErasePage : codePage(spiAddr);
    spiGrant = 1'b0;
    if (!spiErase && spiAddr >= `FNV_NRM0_SPI && spiAddr < `FNV_NRM1_SPI + `FNV_PAGE_BYTES) begin
      spiPage = (spiAddr < `FNV_NRM1_SPI) ? `FNV_NRM0_PAGE : `FNV_NRM1_PAGE;
    end
    if (spiReq && ready) begin
      if (spiCfgSel) begin
        spiGrant = spiRead || !readbackDisabled;
      end else if (spiPage == `FNV_EXT0_PAGE || spiPage == `FNV_EXT1_PAGE) begin
        spiGrant = 1'b0;
      end else if (spiPage > `FNV_NRM1_PAGE) begin
        spiGrant = 1'b0;
      end else begin
        spiGrant = !readbackDisabled;
      end
    end
  end

endmodule : fnv_flash_map
`default_nettype wire

// file: tb/fnv_flash_model.sv
// Flash array model answering boot reads
`default_nettype none
module fnv_flash_model (
  // Clock and boot read port
  input  wire logic        clk,
  input  wire logic        bootRead,
  input  wire logic        bootCfgSel,
  input  wire logic [15:0] bootAddr,
  output var  logic [7:0]  bootData,
  // Stored configuration chosen by the host
  input  wire logic [7:0]  cfgCount,
  input  wire logic [7:0]  cfgRdis,
  input  wire logic [7:0]  cfgDebug,
  input  wire logic        topOdd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial bootData = 8'h5a;
  // Data a cycle after the address; idle data toggles so nothing stale passes
  always @(posedge clk)
    if (!bootRead) bootData <= ~bootData;
    else if (bootCfgSel) case (bootAddr[8:0])
      9'h020: bootData <= cfgCount;
      9'h023: bootData <= cfgRdis;
      9'h024: bootData <= cfgDebug;
      default: bootData <= 8'hff;
    endcase
    else bootData <= (bootAddr == 16'hffff) ? {7'h00, topOdd} : 8'h03;
endmodule : fnv_flash_model
`default_nettype wire

// file: tb/fnv_flash_map_chk.sv
// Port assertions for the flash map block
`default_nettype none
module fnv_flash_map_chk (
  // Shared ports, grouped by width to keep it short
  input wire logic        clk, reset_n, mcuReq, mcuWrite, mcuErase, mcuDataSpace,
  input wire logic        mcuGrant, mcuInData, spiReq, spiErase, spiCfgSel, spiGrant,
  input wire logic        spiDisableCmd, spiEraseAllCmd, ready, readbackDisabled,
  input wire logic        protectedStartSelect,
  input wire logic [15:0] mcuAddr, startAddr,
  input wire logic [5:0]  mcuPage, spiErasePage,
  input wire logic [7:0]  unprotectedPageCount
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  boot_len_a: assert property ($rose(reset_n) |-> !ready ##19 !ready ##1 ready)
    else $error("ready timing wrong");
  no_early_a: assert property (!ready |-> !mcuGrant && !spiGrant)
    else $error("grant before boot done");
  rdis_set_a: assert property (ready && spiDisableCmd && !spiEraseAllCmd |=> readbackDisabled)
    else $error("disable not taken");
  rdis_block_a: assert property (readbackDisabled && spiReq && !spiCfgSel |-> !spiGrant)
    else $error("main access while disabled");
  spi_ext_a: assert property (spiReq && spiErase && spiErasePage inside {6'h20, 6'h21} |-> !spiGrant)
    else $error("spi reached extended page");
  mcu_nv_a: assert property (ready && mcuReq && !mcuErase && mcuDataSpace && mcuAddr >= 16'hfa00 |->
    mcuInData && mcuPage == (mcuAddr[10] ? {5'h11, mcuAddr[9]} : {5'h10, mcuAddr[8]}))
    else $error("data page decode wrong");
  mcu_prot_a: assert property (mcuReq && mcuWrite && !mcuErase && !mcuDataSpace && mcuAddr < 16'h4000 &&
    unprotectedPageCount < 8'h20 && mcuAddr[13:9] >= unprotectedPageCount[4:0] |-> !mcuGrant)
    else $error("protected page written");
  start_a: assert property (ready |-> startAddr ==
    ((protectedStartSelect && unprotectedPageCount < 8'h20) ? {unprotectedPageCount[6:0], 9'h000} : 16'h0000))
    else $error("start address wrong");
  cover property (ready && readbackDisabled);
  cover property (ready && protectedStartSelect);
  cover property (ready && mcuReq && !mcuGrant);
endmodule : fnv_flash_map_chk
bind fnv_flash_map fnv_flash_map_chk i_chk (.*);
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the flash map block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // Clock, reset and array model
  logic clk, reset_n, topOdd, bootRead, bootCfgSel;
  logic [7:0] cfgCount, cfgRdis, cfgDebug, bootData, unprotectedPageCount;
  logic [15:0] bootAddr, mcuAddr, spiAddr, startAddr;
  // Requests and answers
  logic mcuReq, mcuWrite, mcuErase, mcuDataSpace, spiReq, spiRead, spiErase, spiCfgSel;
  logic spiDisableCmd, spiEraseAllCmd, mcuGrant, mcuInData, spiGrant;
  logic [5:0] mcuErasePage, spiErasePage, mcuPage, spiPage;
  logic ready, readbackDisabled, hwDebugEnable, protectedStartSelect;
  int badCount, cmpCount, cycles;
  fnv_flash_map i_dut (.clk, .reset_n, .bootRead, .bootCfgSel, .bootAddr, .bootData,
    .mcuReq, .mcuWrite, .mcuErase, .mcuDataSpace, .mcuAddr, .mcuErasePage, .mcuGrant,
    .mcuInData, .mcuPage, .spiReq, .spiRead, .spiErase, .spiCfgSel, .spiAddr,
    .spiErasePage, .spiDisableCmd, .spiEraseAllCmd, .spiGrant, .spiPage, .ready,
    .unprotectedPageCount, .readbackDisabled, .hwDebugEnable, .protectedStartSelect, .startAddr);
  fnv_flash_model i_mdl (.clk, .bootRead, .bootCfgSel, .bootAddr, .bootData,
    .cfgCount, .cfgRdis, .cfgDebug, .topOdd);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Hang guard, far above the hundred or so cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      badCount++;
      conclude();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      badCount++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    if (badCount == 0 && cmpCount > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // Reset with a given stored configuration, then judge the loaded values
  task automatic boot(input logic [7:0] c, r, d, input logic o);
    @(posedge clk);
    reset_n <= 1'b0;
    cfgCount <= c;
    cfgRdis <= r;
    cfgDebug <= d;
    topOdd <= o;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    for (int n = 0; n < 40 && ready !== 1'b1; n++) @(posedge clk);
    @(negedge clk);
    check(unprotectedPageCount, c);
    check(readbackDisabled, r != 8'hff);
    check(hwDebugEnable, d != 8'hff);
    check(startAddr, (o && c < 8'h20) ? {c[6:0], 9'h000} : 16'h0000);
  endtask : boot
  task automatic mcu(input logic w, e, s, input logic [15:0] a, input logic [5:0] p);
    @(posedge clk);
    mcuReq <= 1'b1;
    mcuWrite <= w;
    mcuErase <= e;
    mcuDataSpace <= s;
    mcuAddr <= a;
    mcuErasePage <= p;
    @(negedge clk);
  endtask : mcu
  task automatic spi(input logic rd, e, s, input logic [15:0] a, input logic [5:0] p);
    @(posedge clk);
    spiReq <= 1'b1;
    spiRead <= rd;
    spiErase <= e;
    spiCfgSel <= s;
    spiAddr <= a;
    spiErasePage <= p;
    @(negedge clk);
  endtask : spi
  // One-cycle command pulse: disable or erase-all
  task automatic pulse(input logic dis);
    @(posedge clk);
    spiDisableCmd <= dis;
    spiEraseAllCmd <= !dis;
    @(posedge clk);
    spiDisableCmd <= 1'b0;
    spiEraseAllCmd <= 1'b0;
  endtask : pulse
  // Count of twelve: page 11 open, page 12 shut
  task automatic mcu_scen();
    mcu(1'h1, 1'h0, 1'h0, 16'h17fe, 6'h00);
    check(mcuGrant, 1'h1);
    mcu(1'h1, 1'h0, 1'h0, 16'h1800, 6'h00);
    check(mcuGrant, 1'h0);
    mcu(1'h1, 1'h0, 1'h1, 16'hfb10, 6'h00); // single write, data space
    check({mcuGrant, mcuInData, mcuPage}, {2'h3, 6'h21});
    mcu(1'h1, 1'h0, 1'h1, 16'hfe00, 6'h00);
    check(mcuPage, 6'h23);
    mcu(1'h0, 1'h1, 1'h1, 16'h0000, 6'h23);
    check(mcuGrant, 1'h1);
    mcu(1'h0, 1'h1, 1'h1, 16'h0000, 6'h24);
    check(mcuGrant, 1'h0);
  endtask : mcu_scen
  task automatic spi_scen();
    spi(1'h1, 1'h0, 1'h0, 16'h4610, 6'h00);
    check({spiGrant, spiPage}, {1'h1, 6'h23});
    spi(1'h0, 1'h1, 1'h0, 16'h0000, 6'h21);
    check(spiGrant, 1'h0);
    spi(1'h0, 1'h1, 1'h0, 16'h0000, 6'h1f);
    check(spiGrant, 1'h1);
    pulse(1'h1);
    spi(1'h1, 1'h0, 1'h0, 16'h0100, 6'h00);
    check({readbackDisabled, spiGrant}, 2'h2);
    spi(1'h1, 1'h0, 1'h1, 16'h0023, 6'h00);
    check(spiGrant, 1'h1);
    pulse(1'h0);
    spi(1'h1, 1'h0, 1'h0, 16'h0100, 6'h00);
    check({readbackDisabled, spiGrant}, 2'h1);
  endtask : spi_scen
  initial begin
    {reset_n, mcuReq, mcuWrite, mcuErase, mcuDataSpace, spiReq, spiRead} = '0;
    {spiErase, spiCfgSel, spiDisableCmd, spiEraseAllCmd} = '0;
    {mcuAddr, spiAddr, mcuErasePage, spiErasePage} = '0;
    {cfgCount, cfgRdis, cfgDebug, topOdd} = '1;
    boot(8'hff, 8'hff, 8'hff, 1'h1);
    boot(8'h0c, 8'hff, 8'h00, 1'h1);
    mcu_scen();
    spi_scen();
    boot(8'h00, 8'h00, 8'hff, 1'h0);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
